// ### pkg/sesc_regs.svh
/*
 * Command words, mode values and field positions for the sample
 * counter setup sequence driven by the host-side sequencer.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SESC_REGS_SVH
`define SESC_REGS_SVH

// ------------------------------------------------------------
// Counter command words
// ------------------------------------------------------------
`define SESC_CMD_SEL_MODE    16'hff01
`define SESC_CMD_SEL_LOAD    16'hff09
`define SESC_CMD_LOAD        16'hff41
`define SESC_CMD_STEP        16'hfff1
`define SESC_CMD_ARM         16'hff21

// ------------------------------------------------------------
// Mode values and count limits
// ------------------------------------------------------------
`define SESC_MODE_STD        16'h0325
`define SESC_MODE_FAST       16'h1325
`define SESC_COUNT_MIN       16'h0002
`define SESC_COUNT_MAX       16'hffff
`define SESC_LIST_STD        16
`define SESC_LIST_BIG        512

// ------------------------------------------------------------
// First command register: divide bit position
// ------------------------------------------------------------
`define SESC_DIV_BIT         3
`define SESC_CMD1_RST        16'h0000

// ------------------------------------------------------------
// Reset values and entry stepping
// ------------------------------------------------------------
`define SESC_DATA_RST        16'h0000
`define SESC_COUNT_LAST      16'h0001
`define SESC_COUNT_STEP      16'h0001
`define SESC_ENTRY_FIRST     10'h000
`define SESC_ENTRY_STEP      10'h001
`define SESC_LIST_EMPTY      10'h000
`define SESC_LIST_MIN        10'h001

`endif

// ### pkg/sesc_pkg.sv
/*
 * Types shared by the sample counter sequencer.
 * Assumes sesc_regs.svh is on the include path.
 */
package sesc_pkg;
    typedef enum logic [1:0] {
        SESC_TGT_CMD,
        SESC_TGT_DATA,
        SESC_TGT_CMD1
    } sesc_tgt_e;

    typedef enum logic [3:0] {
        SESC_IDLE,
        SESC_SEL_MODE,
        SESC_WR_MODE,
        SESC_SEL_LOAD,
        SESC_WR_COUNT,
        SESC_LOAD,
        SESC_STEP,
        SESC_ARM,
        SESC_SET_DIV,
        SESC_RUN,
        SESC_ERR
    } sesc_state_e;
endpackage

// ### hdl/sesc_ctrl.sv
/*
 * Host-side sequencer for the scan-list sample counter: writes the
 * command word sequence and the divide bit, then tracks conversions to
 * advance the scan-list entry with N samples per entry.
 * Assumes a simple write-strobe path to the board's command, data and
 * first command registers, each write accepted when WR_READY is high.
 */
// Notes on behaviour
// - Board setup first, then modules, chassis, enable
// - Parallel scanning needs only board programming
// - Use channel-scanning path for multiplexed scanning
// - Begin counter setup with mode select word
// - Write counter mode value to data register
// - Select counter load register next
// - Write samples-per-entry count, 2 to 65535
// - Load command transfers count into counter
// - Step command steps counter once
// - Arm command starts sample counting
// - Finally set divide bit in first command
// - Several readings per channel for multi-chassis
`include "sesc_regs.svh"

module sesc_ctrl #(
    parameter int         LIST_DEPTH = `SESC_LIST_STD,
    parameter logic [15:0] CMD1_BASE = `SESC_CMD1_RST
) (
    input  wire logic                 MCLK,
    input  wire logic                 RST,
    input  wire logic                 START,
    input  wire logic                 MULTI_SAMPLE,
    input  wire logic                 FAST_BOARD,
    input  wire logic [15:0]          SAMPLE_COUNT,
    input  wire logic [9:0]           LIST_LEN,
    input  wire logic                 WR_READY,
    input  wire logic                 CONV_DONE,
    output logic                      WR_VALID,
    output sesc_pkg::sesc_tgt_e       WR_TARGET,
    output logic [15:0]               WR_DATA,
    output logic                      SETUP_DONE,
    output logic                      SETUP_ERROR,
    output logic [9:0]                ENTRY_INDEX,
    output logic                      ENTRY_ADVANCE,
    output logic                      samples_per_entry_divide_bit
);
    import sesc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic count_ok(input logic [15:0] n);
        count_ok = (n >= `SESC_COUNT_MIN) && (n <= `SESC_COUNT_MAX);
    endfunction

    function automatic logic [9:0] list_cap(input logic [9:0] len);
        if (len == `SESC_LIST_EMPTY)
            list_cap = `SESC_LIST_MIN;
        else if (len > 10'(LIST_DEPTH))
            list_cap = 10'(LIST_DEPTH);
        else
            list_cap = len;
    endfunction

    // Last conversion of the current entry; one-sample mode ends every time
    function automatic logic last_sample(input logic multi, input logic [15:0] left);
        last_sample = !multi || (left <= `SESC_COUNT_LAST);
    endfunction

    function automatic logic [9:0] entry_after(input logic [9:0] idx, input logic [9:0] len);
        if (idx + `SESC_ENTRY_STEP >= len)
            entry_after = `SESC_ENTRY_FIRST;
        else
            entry_after = idx + `SESC_ENTRY_STEP;
    endfunction

    // Higher-speed boards need a different counter mode value
    function automatic logic [15:0] mode_word(input logic fast);
        if (fast)
            mode_word = `SESC_MODE_FAST;
        else
            mode_word = `SESC_MODE_STD;
    endfunction

    function automatic logic [15:0] div_word(input logic [15:0] base);
        div_word = base | (16'h0001 << `SESC_DIV_BIT);
    endfunction

    sesc_state_e state_r;
    sesc_state_e state_nxt;
    logic [15:0] count_r;
    logic [15:0] remain_r;
    logic        multi_r;
    logic        fast_r;
    logic [9:0]  len_r;
    logic        wr_fire;
    logic        start_take;
    logic        entry_end;

    assign wr_fire = WR_VALID && WR_READY;
    assign start_take = (state_r == SESC_IDLE) && START;
    assign entry_end  = (state_r == SESC_RUN) && CONV_DONE && last_sample(multi_r, remain_r);

    // ------------------------------------------------------------
    // Setup sequence
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SESC_IDLE: begin
                if (START) begin
                    if (!MULTI_SAMPLE)
                        state_nxt = SESC_RUN;
                    else if (!count_ok(SAMPLE_COUNT))
                        state_nxt = SESC_ERR;
                    else
                        state_nxt = SESC_SEL_MODE;
                end
            end
            SESC_SEL_MODE: begin
                if (wr_fire)
                    state_nxt = SESC_WR_MODE;
            end
            SESC_WR_MODE: begin
                if (wr_fire)
                    state_nxt = SESC_SEL_LOAD;
            end
            SESC_SEL_LOAD: begin
                if (wr_fire)
                    state_nxt = SESC_WR_COUNT;
            end
            SESC_WR_COUNT: begin
                if (wr_fire)
                    state_nxt = SESC_LOAD;
            end
            SESC_LOAD: begin
                if (wr_fire)
                    state_nxt = SESC_STEP;
            end
            SESC_STEP: begin
                if (wr_fire)
                    state_nxt = SESC_ARM;
            end
            SESC_ARM: begin
                if (wr_fire)
                    state_nxt = SESC_SET_DIV;
            end
            SESC_SET_DIV: begin
                if (wr_fire)
                    state_nxt = SESC_RUN;
            end
            // Only reset leaves run and error; START is taken once
            SESC_RUN:      state_nxt = SESC_RUN;
            SESC_ERR:      state_nxt = SESC_ERR;
            default:       state_nxt = SESC_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            state_r <= SESC_IDLE;
        else
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------
    // Setup inputs
    // ------------------------------------------------------------
    // Captured at start so a mid-setup change is ignored
    always_ff @(posedge MCLK) begin
        if (RST)
            count_r <= `SESC_COUNT_MIN;
        else if (start_take)
            count_r <= SAMPLE_COUNT;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            multi_r <= 1'b0;
        else if (start_take)
            multi_r <= MULTI_SAMPLE;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            fast_r <= 1'b0;
        else if (start_take)
            fast_r <= FAST_BOARD;
    end

    // List length clamped once here, not on every advance
    always_ff @(posedge MCLK) begin
        if (RST)
            len_r <= `SESC_LIST_MIN;
        else if (start_take)
            len_r <= list_cap(LIST_LEN);
    end

    // ------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------
    always_comb begin
        WR_VALID  = 1'b0;
        WR_TARGET = SESC_TGT_CMD;
        case (state_r)
            SESC_WR_MODE: begin
                WR_VALID  = 1'b1;
                WR_TARGET = SESC_TGT_DATA;
            end
            SESC_WR_COUNT: begin
                WR_VALID  = 1'b1;
                WR_TARGET = SESC_TGT_DATA;
            end
            SESC_SET_DIV: begin
                WR_VALID  = 1'b1;
                WR_TARGET = SESC_TGT_CMD1;
            end
            SESC_SEL_MODE, SESC_SEL_LOAD, SESC_LOAD, SESC_STEP, SESC_ARM: begin
                WR_VALID  = 1'b1;
                WR_TARGET = SESC_TGT_CMD;
            end
            default: begin
                WR_VALID  = 1'b0;
                WR_TARGET = SESC_TGT_CMD;
            end
        endcase
    end

    // Data held in flops; loaded one cycle ahead from the next state
    always_ff @(posedge MCLK) begin
        if (RST) begin
            WR_DATA <= `SESC_DATA_RST;
        end else begin
            case (state_nxt)
                SESC_SEL_MODE: WR_DATA <= `SESC_CMD_SEL_MODE;
                SESC_WR_MODE:  WR_DATA <= mode_word(fast_r);
                SESC_SEL_LOAD: WR_DATA <= `SESC_CMD_SEL_LOAD;
                SESC_WR_COUNT: WR_DATA <= count_r;
                SESC_LOAD:     WR_DATA <= `SESC_CMD_LOAD;
                SESC_STEP:     WR_DATA <= `SESC_CMD_STEP;
                SESC_ARM:      WR_DATA <= `SESC_CMD_ARM;
                SESC_SET_DIV:  WR_DATA <= div_word(CMD1_BASE);
                default:       WR_DATA <= WR_DATA;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST)
            SETUP_DONE <= 1'b0;
        else
            SETUP_DONE <= (state_nxt == SESC_RUN);
    end

    // Sticky: only reset leaves the error state
    always_ff @(posedge MCLK) begin
        if (RST)
            SETUP_ERROR <= 1'b0;
        else
            SETUP_ERROR <= (state_nxt == SESC_ERR);
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            samples_per_entry_divide_bit <= 1'b0;
        else if (state_r == SESC_SET_DIV && wr_fire)
            samples_per_entry_divide_bit <= 1'b1;
    end

    // ------------------------------------------------------------
    // Entry tracking
    // ------------------------------------------------------------
    // Models the board's advance so the host knows which entry is live
    always_ff @(posedge MCLK) begin
        if (RST)
            remain_r <= `SESC_COUNT_MIN;
        else if (state_r != SESC_RUN || entry_end)
            remain_r <= count_r;
        else if (CONV_DONE)
            remain_r <= remain_r - `SESC_COUNT_STEP;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            ENTRY_INDEX <= `SESC_ENTRY_FIRST;
        else if (state_r != SESC_RUN)
            ENTRY_INDEX <= `SESC_ENTRY_FIRST;
        else if (entry_end)
            ENTRY_INDEX <= entry_after(ENTRY_INDEX, len_r);
    end

    // One-cycle pulse per finished entry
    always_ff @(posedge MCLK) begin
        if (RST)
            ENTRY_ADVANCE <= 1'b0;
        else
            ENTRY_ADVANCE <= entry_end;
    end
endmodule

// ### dv/sesc_ctrl_assertions.sv
/* Concurrent checks on the sequencer ports.
   Assumes it is bound to every sesc_ctrl instance. */
// ----------------------------------------
// Port checker
// ----------------------------------------
module sesc_ctrl_assertions
    import sesc_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        WR_READY,
    input wire logic        WR_VALID,
    input wire sesc_tgt_e   WR_TARGET,
    input wire logic [15:0] WR_DATA,
    input wire logic        SETUP_DONE,
    input wire logic        SETUP_ERROR,
    input wire logic        ENTRY_ADVANCE,
    input wire logic        samples_per_entry_divide_bit
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    logic acc;
    assign acc = WR_VALID && WR_READY;
    chk_first_sel: assert property (
        $rose(WR_VALID) |-> WR_DATA == 16'hff01 && WR_TARGET == SESC_TGT_CMD)
        else $error("setup opens with wrong word");
    chk_mode_value: assert property (
        acc && WR_TARGET == SESC_TGT_CMD && WR_DATA == 16'hff01
        |=> WR_TARGET == SESC_TGT_DATA && WR_DATA inside {16'h0325, 16'h1325})
        else $error("mode value wrong");
    chk_after_data: assert property (
        acc && WR_TARGET == SESC_TGT_DATA |=> WR_VALID && WR_TARGET == SESC_TGT_CMD
        && WR_DATA inside {16'hff09, 16'hff41}) else $error("data not followed by select");
    chk_count_range: assert property (
        acc && WR_TARGET == SESC_TGT_CMD && WR_DATA == 16'hff09
        |=> WR_TARGET == SESC_TGT_DATA && WR_DATA >= 16'h0002)
        else $error("count out of range");
    chk_step_next: assert property (
        acc && WR_TARGET == SESC_TGT_CMD && WR_DATA == 16'hff41 |=> WR_DATA == 16'hfff1)
        else $error("step missing");
    chk_arm_next: assert property (
        acc && WR_TARGET == SESC_TGT_CMD && WR_DATA == 16'hfff1 |=> WR_DATA == 16'hff21)
        else $error("arm missing");
    chk_div_word: assert property (
        acc && WR_DATA == 16'hff21 && WR_TARGET == SESC_TGT_CMD
        |=> WR_TARGET == SESC_TGT_CMD1 && WR_DATA[3]) else $error("divide word wrong");
    chk_setup_end: assert property (
        acc && WR_TARGET == SESC_TGT_CMD1 |=> !WR_VALID && SETUP_DONE
        && samples_per_entry_divide_bit) else $error("setup did not finish");
    chk_write_hold: assert property (
        WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_DATA) && $stable(WR_TARGET))
        else $error("write dropped before accept");
    chk_err_quiet: assert property (
        SETUP_ERROR |-> !WR_VALID && !SETUP_DONE) else $error("writes after bad count");
    chk_adv_run: assert property (
        ENTRY_ADVANCE |-> SETUP_DONE) else $error("advance outside run");
endmodule
bind sesc_ctrl sesc_ctrl_assertions u_sesc_ctrl_assertions (.MCLK, .RST, .WR_READY,
    .WR_VALID, .WR_TARGET, .WR_DATA, .SETUP_DONE, .SETUP_ERROR, .ENTRY_ADVANCE,
    .samples_per_entry_divide_bit);

// ### dv/sesc_board_model.sv
/* Board model: command and data writes, the sample counter and
   conversion pulses. Assumes the sequencer's clock. */
// ----------------------------------------
// Board model
// ----------------------------------------
module sesc_board_model
    import sesc_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        WR_VALID,
    input wire sesc_tgt_e   WR_TARGET,
    input wire logic [15:0] WR_DATA,
    input wire logic        slow,
    input wire logic        single,
    input wire logic        conv_req,
    output logic            WR_READY,
    output logic            CONV_DONE,
    output logic [15:0]     mode_r,
    output logic [15:0]     load_r,
    output logic [15:0]     cnt_r,
    output logic            armed_r
);
    logic       sel_load_r;
    logic [1:0] wait_r;
    logic       acc;
    // Slow board takes one write in four
    assign WR_READY = !slow || wait_r == 2'h3;
    assign acc = WR_VALID && WR_READY;
    always_ff @(posedge MCLK) wait_r <= RST ? 2'h0 : wait_r + 2'h1;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            {sel_load_r, mode_r, load_r, cnt_r, armed_r} <= '0;
        end else if (acc && WR_TARGET == SESC_TGT_DATA) begin
            if (sel_load_r)
                load_r <= WR_DATA;
            else
                mode_r <= WR_DATA;
        end else if (acc && WR_TARGET == SESC_TGT_CMD) begin
            case (WR_DATA)
                16'hff01: sel_load_r <= 1'b0;
                16'hff09: sel_load_r <= 1'b1;
                16'hff41: cnt_r <= load_r;
                16'hfff1: cnt_r <= cnt_r - 16'h0001;
                16'hff21: armed_r <= 1'b1;
                default: ;
            endcase
        end
    end
    // No conversions until armed, except in one-sample mode
    always_ff @(posedge MCLK) CONV_DONE <= !RST && conv_req && (armed_r || single);
endmodule

// ### dv/tb.sv
/* Self-checking bench: sequencer against the board model.
   Assumes package, design and checker compiled first. */
// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sesc_pkg::*;
    logic MCLK = 0, RST = 1, START = 0, MULTI_SAMPLE = 0, FAST_BOARD = 0;
    logic slow = 0, conv_req = 0, WR_READY, CONV_DONE, WR_VALID, armed_r;
    logic SETUP_DONE, SETUP_ERROR, ENTRY_ADVANCE, samples_per_entry_divide_bit;
    logic [15:0] SAMPLE_COUNT = 0, WR_DATA, mode_r, load_r, cnt_r;
    logic [9:0]  LIST_LEN = 0, ENTRY_INDEX;
    sesc_tgt_e   WR_TARGET;
    wire         single = !MULTI_SAMPLE;
    int          seed = 93550, failures = 0, compares = 0, convs = 0, advs = 0;
    sesc_ctrl #(.LIST_DEPTH(16)) u_sesc_ctrl (.MCLK, .RST, .START, .MULTI_SAMPLE,
        .FAST_BOARD, .SAMPLE_COUNT, .LIST_LEN, .WR_READY, .CONV_DONE, .WR_VALID, .WR_TARGET,
        .WR_DATA, .SETUP_DONE, .SETUP_ERROR, .ENTRY_INDEX, .ENTRY_ADVANCE,
        .samples_per_entry_divide_bit);
    sesc_board_model u_sesc_board_model (.MCLK, .RST, .WR_VALID, .WR_TARGET, .WR_DATA,
        .slow, .single, .conv_req, .WR_READY, .CONV_DONE, .mode_r, .load_r, .cnt_r, .armed_r);
    function automatic logic [9:0] exp_idx(int c, logic [15:0] n, logic [9:0] l);
        int e;
        e = (l == 0) ? 1 : (l > 16 ? 16 : l);
        return 10'((c / n) % e);
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial forever #20 MCLK = ~MCLK;
    always @(posedge MCLK) if (CONV_DONE === 1'b1) convs++;
    always @(posedge MCLK) if (ENTRY_ADVANCE === 1'b1) advs++;
    // Ten runs of about fifty to ninety cycles each
    initial begin
        #200000;
        failures++;
        print_verdict;
    end
    initial begin
        for (int t = 0; t < 10; t++) begin
            @(posedge MCLK) RST <= 1;
            // Corners: shortest count, largest count, bad count, one sample
            SAMPLE_COUNT <= t == 0 ? 16'h0002 : t == 1 ? 16'hffff : t == 2 ? 16'h0001
                : 16'h0002 + 16'($unsigned($random(seed)) % 9);
            LIST_LEN <= t == 0 ? 10'h000 : (t == 1 || t == 3) ? 10'h3ff : 10'($random(seed));
            MULTI_SAMPLE <= t != 3 && (t < 4 || $random(seed) % 2 == 0);
            FAST_BOARD <= t[0];
            slow <= t[1];
            @(posedge MCLK);
            RST <= 0;
            @(posedge MCLK) START <= 1;
            @(posedge MCLK) START <= 0;
            for (int k = 0; k < 60 && SETUP_DONE !== 1 && SETUP_ERROR !== 1; k++)
                @(negedge MCLK);
            check(SETUP_ERROR, t == 2);
            check(SETUP_DONE, t != 2);
            check(samples_per_entry_divide_bit, MULTI_SAMPLE && t != 2);
            if (MULTI_SAMPLE && t != 2) begin
                check(mode_r, FAST_BOARD ? 16'h1325 : 16'h0325);
                check(load_r, SAMPLE_COUNT);
                check(cnt_r, SAMPLE_COUNT - 16'h0001);
                check(armed_r, 1);
            end
            convs = 0;
            advs = 0;
            // One-sample corner converts every cycle to wrap past a full list
            repeat (40) @(posedge MCLK) conv_req <= t == 3 ? 1'b1 : 1'($random(seed));
            @(posedge MCLK) conv_req <= 0;
            repeat (4) @(negedge MCLK);
            check(ENTRY_INDEX, exp_idx(convs, MULTI_SAMPLE ? SAMPLE_COUNT : 1, LIST_LEN));
            check(advs, convs / (MULTI_SAMPLE ? SAMPLE_COUNT : 16'h0001));
            if (t == 3)
                check(ENTRY_INDEX, 10'h008);
            $display("test %0d done", t);
        end
        print_verdict;
    end
endmodule
